// ### verilog/rf_link_spi_master_setup.sv
// Host controller that sets up and drives the transceiver serial link
`timescale 1ns/1ps
`default_nettype none
module rf_link_spi_master_setup (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic sck,
  output logic mosi,
  input wire logic miso,
  output logic xcvr_select_n,
  input wire logic xcvr_int,
  output logic xcvr_powerdown,
  output logic host_sleep,
  output logic wake
);

  ////////////////////////////////////////////////////////////////////////
  // Register bus slave: one wait cycle, then the access completes
  logic ack_r;
  logic req;
  logic wr_go;
  logic [31:0] rd_word;
  logic [31:0] rdata_r;

  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_r;
  assign wr_go = avs_write && ack_r;
  assign avs_readdata = rdata_r;

  logic wr_ctrl;
  logic wr_tx;
  logic wr_clr;
  logic wr_en;
  assign wr_ctrl = wr_go && (avs_address == rf_link_pkg::CTRL_OFS);
  assign wr_tx = wr_go && (avs_address == rf_link_pkg::TXDATA_OFS);
  assign wr_clr = wr_go && (avs_address == rf_link_pkg::IRQ_CLEAR_OFS);
  assign wr_en = wr_go && (avs_address == rf_link_pkg::IRQ_ENABLE_OFS);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic miso_m;
  logic miso_s;
  logic int_m;
  logic int_s;

  always_ff @(posedge clk) begin
    if (srst) begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
      int_m <= 1'b0;
      int_s <= 1'b0;
    end else begin
      miso_m <= miso;
      miso_s <= miso_m;
      int_m <= xcvr_int;
      int_s <= int_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register with refusal of illegal settings
  rf_link_pkg::ctrl_type ctrl_r;
  rf_link_pkg::ctrl_type ctrl_nxt;
  rf_link_pkg::ctrl_type wd;
  logic ctrl_refused;
  logic busy;
  logic wake_evt;
  logic [1:0] wd_rate;
  logic rate_bad;
  logic setup_frozen;

  assign wd = rf_link_pkg::ctrl_type'(avs_writedata[rf_link_pkg::CTRL_W-1:0]);
  assign wd_rate = {wd.rate_mode_sel_hi, wd.rate_mode_sel_lo};
  assign setup_frozen = ctrl_r.serial_bus_enable && wd.serial_bus_enable;
  // Slave code, or a shift clock faster than the transceiver can follow
  assign rate_bad = (wd_rate == rf_link_pkg::RATE_SLAVE)
      || (rf_link_pkg::period_cycles(wd.base_clock_source_sel, wd_rate)
      < rf_link_pkg::MIN_PERIOD_CYC);

  always_comb begin
    ctrl_nxt = ctrl_r;
    ctrl_refused = 1'b0;
    if (wr_ctrl) begin
      ctrl_nxt = wd;
      if (setup_frozen) begin
        // Setup is frozen while the port runs; only the run-time bits move
        ctrl_nxt = ctrl_r;
        ctrl_nxt.xcvr_select = wd.xcvr_select;
        ctrl_nxt.xcvr_powerdown = wd.xcvr_powerdown;
        ctrl_nxt.host_sleep = wd.host_sleep;
        ctrl_nxt.int_active_high = wd.int_active_high;
        ctrl_nxt.global_irq_en = wd.global_irq_en;
        ctrl_nxt.pin_irq_en = wd.pin_irq_en;
      end else if (rate_bad) begin
        ctrl_nxt.rate_mode_sel_hi = ctrl_r.rate_mode_sel_hi;
        ctrl_nxt.rate_mode_sel_lo = ctrl_r.rate_mode_sel_lo;
        ctrl_nxt.base_clock_source_sel = ctrl_r.base_clock_source_sel;
        ctrl_refused = 1'b1;
      end
      if (ctrl_nxt.serial_bus_enable && !rf_link_pkg::cfg_legal(ctrl_nxt)) begin
        ctrl_nxt.serial_bus_enable = 1'b0;
        ctrl_refused = 1'b1;
      end
      if (busy && (wd.xcvr_select != ctrl_r.xcvr_select)) begin
        ctrl_nxt.xcvr_select = ctrl_r.xcvr_select;
        ctrl_refused = 1'b1;
      end
      if (ctrl_nxt.host_sleep && !ctrl_r.host_sleep && !ctrl_r.xcvr_powerdown) begin
        ctrl_nxt.host_sleep = 1'b0;
        ctrl_refused = 1'b1;
      end
      // Also catches one write that sets sleep and drops power-down together
      if (ctrl_nxt.host_sleep && !ctrl_nxt.xcvr_powerdown) begin
        ctrl_nxt.xcvr_powerdown = 1'b1;
        ctrl_refused = 1'b1;
      end
    end
    if (wake_evt) begin
      ctrl_nxt.host_sleep = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer start and shift engine
  logic start_ok;
  logic tx_refused;
  logic start;
  logic done;
  logic [rf_link_pkg::DATA_W-1:0] rx_data;
  logic [rf_link_pkg::HALF_W-1:0] half_m1;

  // A byte may only go out with the port enabled and the select held
  assign start_ok = ctrl_r.serial_bus_enable && ctrl_r.xcvr_select && !busy;
  assign start = wr_tx && start_ok;
  assign tx_refused = wr_tx && !start_ok;
  assign half_m1 = rf_link_pkg::HALF_W'(rf_link_pkg::period_cycles(
      ctrl_r.base_clock_source_sel, {ctrl_r.rate_mode_sel_hi, ctrl_r.rate_mode_sel_lo}) / 2 - 1);

  spi_shift_engine #(
    .WIDTH(rf_link_pkg::DATA_W),
    .CNT_W(rf_link_pkg::HALF_W)
  ) u_engine (
    .clk(clk),
    .srst(srst),
    .start(start),
    .tx_data(avs_writedata[rf_link_pkg::DATA_W-1:0]),
    .half_m1(half_m1),
    .miso_s(miso_s),
    .busy(busy),
    .done(done),
    .rx_data(rx_data),
    .sck(sck),
    .mosi(mosi)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transceiver interrupt line: serviced or wake-up only
  logic int_active;
  logic int_d_r;
  logic int_rise;
  logic service;
  logic wake_r;

  assign int_active = ctrl_r.int_active_high ? int_s : !int_s;
  // Edges come from the raw line, so a polarity change or a line found
  // active at reset release is not taken for a request
  assign int_rise = ctrl_r.int_active_high ? (int_s && !int_d_r)
      : (!int_s && int_d_r);
  assign service = ctrl_r.global_irq_en && ctrl_r.pin_irq_en;
  assign wake_evt = int_rise && !service;

  ////////////////////////////////////////////////////////////////////////
  // Event status, enable and clear
  rf_link_pkg::irq_type ist_r;
  rf_link_pkg::irq_type ist_set;
  logic [rf_link_pkg::IRQ_W-1:0] ist_nxt;
  logic [rf_link_pkg::IRQ_W-1:0] ien_r;
  logic [rf_link_pkg::IRQ_W-1:0] clr_mask;

  assign ist_set.xfer_done = done;
  assign ist_set.xcvr_int = int_rise && service;
  assign ist_set.wake = wake_evt;
  assign ist_set.cfg_error = ctrl_refused || tx_refused;
  assign clr_mask = wr_clr ? avs_writedata[rf_link_pkg::IRQ_W-1:0] : '0;
  // A set arriving with its clear survives
  assign ist_nxt = (ist_r & ~clr_mask) | ist_set;
  assign irq = |(ist_r & ien_r);

  ////////////////////////////////////////////////////////////////////////
  // Read data selection
  rf_link_pkg::status_type status;
  assign status.int_level = int_active;
  assign status.cfg_legal = rf_link_pkg::cfg_legal(ctrl_r);
  assign status.busy = busy;

  always_comb begin
    rd_word = '0;
    unique case (avs_address)
      rf_link_pkg::CTRL_OFS: rd_word[rf_link_pkg::CTRL_W-1:0] = ctrl_r;
      rf_link_pkg::RXDATA_OFS: rd_word[rf_link_pkg::DATA_W-1:0] = rx_data;
      rf_link_pkg::STATUS_OFS: rd_word[rf_link_pkg::STATUS_W-1:0] = status;
      rf_link_pkg::IRQ_STATUS_OFS: rd_word[rf_link_pkg::IRQ_W-1:0] = ist_r;
      rf_link_pkg::IRQ_ENABLE_OFS: rd_word[rf_link_pkg::IRQ_W-1:0] = ien_r;
      default: rd_word = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
      ctrl_r <= rf_link_pkg::CTRL_RESET;
      ist_r <= rf_link_pkg::IRQ_RESET;
      ien_r <= rf_link_pkg::IRQ_RESET;
      int_d_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
      if (avs_read && !ack_r) begin
        rdata_r <= rd_word;
      end
      ctrl_r <= ctrl_nxt;
      ist_r <= ist_nxt;
      if (wr_en) begin
        ien_r <= avs_writedata[rf_link_pkg::IRQ_W-1:0];
      end
      int_d_r <= int_s;
      wake_r <= wake_evt;
    end
  end

  // Software owns the select; the hardware select pin stays a plain output
  assign xcvr_select_n = !ctrl_r.xcvr_select;
  assign xcvr_powerdown = ctrl_r.xcvr_powerdown;
  assign host_sleep = ctrl_r.host_sleep;
  assign wake = wake_r;

endmodule // rf_link_spi_master_setup
`default_nettype wire

// ### pkg/rf_link_pkg.sv
// Constants, types and helpers for the transceiver serial link controller
package rf_link_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int SLAVE_MAX_HZ = 5_000_000;
  // Least shift clock period, rounded up to whole system clocks
  localparam int MIN_PERIOD_CYC = (CLK_HZ + SLAVE_MAX_HZ - 1) / SLAVE_MAX_HZ;

  localparam int DATA_W = 8;
  localparam int HALF_W = 5;

  localparam int SRC_HALF_DIV = 2;
  localparam int SRC_FULL_DIV = 1;
  localparam int RATE_DIV_1 = 1;
  localparam int RATE_DIV_4 = 4;
  localparam int RATE_DIV_16 = 16;

  // Word offsets on the register bus
  localparam logic [2:0] CTRL_OFS = 3'h0;
  localparam logic [2:0] TXDATA_OFS = 3'h1;
  localparam logic [2:0] RXDATA_OFS = 3'h2;
  localparam logic [2:0] STATUS_OFS = 3'h3;
  localparam logic [2:0] IRQ_STATUS_OFS = 3'h4;
  localparam logic [2:0] IRQ_CLEAR_OFS = 3'h5;
  localparam logic [2:0] IRQ_ENABLE_OFS = 3'h6;

  localparam logic [1:0] RATE_SLAVE = 2'h3;

  typedef struct packed {
    logic pin_irq_en;
    logic global_irq_en;
    logic int_active_high;
    logic host_sleep;
    logic xcvr_powerdown;
    logic xcvr_select;
    logic serial_bus_enable;
    logic pin_share_enable;
    logic hw_chip_select_enable;
    logic clock_polarity_sel;
    logic data_phase_sel;
    logic bit_order_sel;
    logic base_clock_source_sel;
    logic rate_mode_sel_hi;
    logic rate_mode_sel_lo;
  } ctrl_type;
  localparam int CTRL_W = 15;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;

  typedef struct packed {
    logic cfg_error;
    logic wake;
    logic xcvr_int;
    logic xfer_done;
  } irq_type;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  typedef struct packed {
    logic int_level;
    logic cfg_legal;
    logic busy;
  } status_type;
  localparam int STATUS_W = 3;

  function automatic int period_cycles(input logic src_full, input logic [1:0] rate);
    int base;
    base = src_full ? SRC_FULL_DIV : SRC_HALF_DIV;
    unique case (rate)
      2'h0: return base * RATE_DIV_1;
      2'h1: return base * RATE_DIV_4;
      default: return base * RATE_DIV_16;
    endcase
  endfunction

  function automatic logic cfg_legal(input ctrl_type c);
    logic [1:0] rate;
    rate = {c.rate_mode_sel_hi, c.rate_mode_sel_lo};
    return (rate != RATE_SLAVE)
      && (period_cycles(c.base_clock_source_sel, rate) >= MIN_PERIOD_CYC)
      && c.bit_order_sel
      && c.data_phase_sel && c.clock_polarity_sel
      && !c.hw_chip_select_enable
      && c.pin_share_enable;
  endfunction

endpackage

// ### verilog/spi_shift_engine.sv
// Byte shifter driving the transceiver clock and data pins
`timescale 1ns/1ps
`default_nettype none
module spi_shift_engine #(
  parameter int WIDTH = 8,
  parameter int CNT_W = 5
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [WIDTH-1:0] tx_data,
  input wire logic [CNT_W-1:0] half_m1,
  input wire logic miso_s,
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] rx_data,
  output logic sck,
  output logic mosi
);
  localparam int BIT_W = $clog2(WIDTH);

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    LOW = 2'b01,
    HIGH = 2'b10
  } eng_state_type;

  eng_state_type state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [BIT_W-1:0] bit_r;
  logic [WIDTH-1:0] sh_r;
  logic [WIDTH-1:0] rx_r;
  logic sck_r;
  logic mosi_r;
  logic done_r;
  logic tick;
  logic [WIDTH-1:0] sh_in;

  assign tick = (cnt_r == '0);
  // Sampled at the trailing end of the high half: the synchroniser lag then
  // still lands after the rising edge, so the bit seen is the settled one
  assign sh_in = {sh_r[WIDTH-2:0], miso_s};
  assign busy = (state_r != IDLE);
  assign done = done_r;
  assign rx_data = rx_r;
  assign sck = sck_r;
  assign mosi = mosi_r;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      rx_r <= '0;
      sck_r <= 1'b1;
      mosi_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        IDLE: begin
          if (start) begin
            sh_r <= tx_data;
            mosi_r <= tx_data[WIDTH-1];
            sck_r <= 1'b0;
            cnt_r <= half_m1;
            bit_r <= BIT_W'(WIDTH - 1);
            state_r <= LOW;
          end
        end
        LOW: begin
          if (tick) begin
            sck_r <= 1'b1;
            cnt_r <= half_m1;
            state_r <= HIGH;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        HIGH: begin
          if (!tick) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (bit_r == '0) begin
            rx_r <= sh_in;
            done_r <= 1'b1;
            state_r <= IDLE;
          end else begin
            sh_r <= sh_in;
            mosi_r <= sh_r[WIDTH-2];
            sck_r <= 1'b0;
            bit_r <= bit_r - 1'b1;
            cnt_r <= half_m1;
            state_r <= LOW;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

endmodule // spi_shift_engine
`default_nettype wire

// ### verification/rf_link_spi_master_setup_sva.sv
// Port assertions for the host serial link controller
`timescale 1ns/1ps
`default_nettype none
module rf_link_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic sck,
  input wire logic mosi,
  input wire logic xcvr_select_n,
  input wire logic xcvr_powerdown,
  input wire logic host_sleep,
  input wire logic wake
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  a_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_low_half: assert property ($fell(sck) |=> !sck)
    else $error("shift clock low half too short");
  a_high_half: assert property ($rose(sck) |=> sck)
    else $error("shift clock high half too short");
  // Slave samples on the rise, so data may only move at the fall
  a_mosi_hold: assert property (($rose(sck) || (!sck && !$fell(sck))) |-> $stable(mosi))
    else $error("data moved away from clock fall");
  a_sck_selected: assert property (!sck |-> !xcvr_select_n)
    else $error("shift clock active while deselected");
  a_sleep_after: assert property ($rose(host_sleep) |-> $past(xcvr_powerdown))
    else $error("host slept before radio power down");
  a_sleep_pd: assert property (host_sleep |-> xcvr_powerdown)
    else $error("radio powered while host sleeps");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
endmodule // rf_link_sva

bind rf_link_spi_master_setup rf_link_sva i_rf_link_sva (.clk(clk), .srst(srst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .sck(sck), .mosi(mosi), .xcvr_select_n(xcvr_select_n), .xcvr_powerdown(xcvr_powerdown),
  .host_sleep(host_sleep), .wake(wake));
`default_nettype wire

// ### verification/xcvr_slave_model.sv
// Behavioural transceiver slave on the serial link
`timescale 1ns/1ps
`default_nettype none
module xcvr_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic select_n,
  input wire logic [7:0] reply,
  input wire logic int_req,
  output logic miso,
  output logic xcvr_int,
  output logic [7:0] got
);
  logic [7:0] sh;
  logic [2:0] cnt;
  assign xcvr_int = int_req;
  initial begin
    got = 8'h00;
    sh = 8'h00;
    cnt = 3'h0;
    miso = 1'b1;
  end
  always @(negedge select_n) cnt = 3'h0;
  // Reply reloads every eighth bit so bytes can follow under one select
  always @(negedge sck) if (!select_n) begin
    if (cnt == 3'h0) sh = reply;
    miso = sh[7];
    sh = {sh[6:0], 1'b0};
    cnt = cnt + 3'h1;
  end
  always @(posedge sck) if (!select_n) got = {got[6:0], mosi};
  // Released line has no pull, so show a changed level rather than the last bit
  always @(posedge select_n) miso = !miso;
endmodule // xcvr_slave_model
`default_nettype wire

// ### verification/test_rf_link_spi_master_setup.sv
// Self-checking bench for the host serial link controller
`timescale 1ns/1ps
`default_nettype none
module test_rf_link_spi_master_setup;
  localparam logic [31:0] GOOD = 32'h0000_00bd;
  logic clk, srst, avs_read, avs_write, avs_waitrequest, irq, sck, mosi, miso;
  logic xcvr_select_n, xcvr_int, xcvr_powerdown, host_sleep, wake, int_req, wake_seen;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] reply, got;
  int err_count, checked, low_cnt;
  rf_link_spi_master_setup i_rf_link_spi_master_setup (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .sck(sck), .mosi(mosi), .miso(miso),
    .xcvr_select_n(xcvr_select_n), .xcvr_int(xcvr_int), .xcvr_powerdown(xcvr_powerdown),
    .host_sleep(host_sleep), .wake(wake));
  xcvr_slave_model i_xcvr_slave_model (.sck(sck), .mosi(mosi), .select_n(xcvr_select_n),
    .reply(reply), .int_req(int_req), .miso(miso), .xcvr_int(xcvr_int), .got(got));
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  always @(posedge clk) begin
    if (!sck) low_cnt <= low_cnt + 1;
    if (wake) wake_seen <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] v, input logic [31:0] e, input string m);
    checked++;
    if (v !== e) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, m, v, e);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk(n < 20, 1'b1, "no bus answer");
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e, m);
  endtask
  task automatic wctl(input logic [31:0] d);
    bus(1'b1, rf_link_pkg::CTRL_OFS, d);
  endtask
  task automatic wclr;
    bus(1'b1, rf_link_pkg::IRQ_CLEAR_OFS, 32'h0000_000f);
  endtask
  task automatic waitfor(ref logic s, input int lim, input string m);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(s, 1'b1, m);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({sck, xcvr_select_n, irq, host_sleep, xcvr_powerdown}, 5'b11000, "reset pins");
    rd(rf_link_pkg::CTRL_OFS, 32'h0000_0000, "ctrl reset");
    bus(1'b1, 3'h7, 32'hffff_ffff);
    rd(3'h7, 32'h0000_0000, "unmapped");
    $display("t_reset done");
  endtask
  // Rate codes first, then each pin setup bit broken in turn
  task automatic t_refuse;
    logic [31:0] bad [8] = '{32'h0000_01bf, 32'h0000_01bc, 32'h0000_01b8, 32'h0000_01b5,
      32'h0000_01ad, 32'h0000_019d, 32'h0000_01fd, 32'h0000_013d};
    foreach (bad[i]) begin
      wctl(GOOD);
      wclr;
      wctl(bad[i]);
      rd(rf_link_pkg::IRQ_STATUS_OFS, 32'h0000_0008, "no refusal");
      bus(1'b0, rf_link_pkg::CTRL_OFS, 32'h0000_0000);
      if (i < 3)
        chk(q[2:0], 3'b101, "rate taken");
      else
        chk(q[8], 1'b0, "enabled early");
    end
    $display("t_refuse done");
  endtask
  task automatic t_xfer(input logic [31:0] cfg, input int h);
    wctl(cfg);
    wctl(cfg | 32'h0000_0300);
    bus(1'b1, rf_link_pkg::IRQ_ENABLE_OFS, 32'h0000_0001);
    rd(rf_link_pkg::STATUS_OFS, 32'h0000_0006, "idle status");
    for (int b = 0; b < 2; b++) begin
      reply = b ? 8'h5a : 8'h96;
      low_cnt = 0;
      bus(1'b1, rf_link_pkg::TXDATA_OFS, b ? 32'h0000_003c : 32'h0000_00a5);
      rd(rf_link_pkg::STATUS_OFS, 32'h0000_0007, "busy status");
      bus(1'b1, rf_link_pkg::TXDATA_OFS, 32'h0000_00ff);
      wctl(cfg | 32'h0000_0100);
      chk(xcvr_select_n, 1'b0, "select dropped in byte");
      rd(rf_link_pkg::IRQ_STATUS_OFS, 32'h0000_0008, "busy writes taken");
      waitfor(irq, 40 * h, "no done irq");
      chk(low_cnt, 8 * h, "shift rate");
      chk(got, b ? 8'h3c : 8'ha5, "sent byte");
      rd(rf_link_pkg::RXDATA_OFS, b ? 32'h0000_005a : 32'h0000_0096, "got byte");
      wclr;
      @(posedge clk);
      chk(irq, 1'b0, "irq not cleared");
    end
    wctl(cfg);
    $display("t_xfer done");
  endtask
  task automatic t_int;
    bus(1'b1, rf_link_pkg::IRQ_ENABLE_OFS, 32'h0000_0002);
    wctl(GOOD | 32'h0000_7000);
    int_req <= 1'b1;
    waitfor(irq, 30, "no service irq");
    rd(rf_link_pkg::IRQ_STATUS_OFS, 32'h0000_0002, "serviced");
    int_req <= 1'b0;
    wclr;
    bus(1'b1, rf_link_pkg::IRQ_ENABLE_OFS, 32'h0000_0000);
    wctl(GOOD | 32'h0000_5000);
    wake_seen = 1'b0;
    int_req <= 1'b1;
    waitfor(wake_seen, 30, "no wake");
    chk(irq, 1'b0, "masked irq");
    rd(rf_link_pkg::IRQ_STATUS_OFS, 32'h0000_0004, "wake only");
    int_req <= 1'b0;
    wclr;
    $display("t_int done");
  endtask
  task automatic t_power;
    wctl(GOOD | 32'h0000_0800);
    rd(rf_link_pkg::IRQ_STATUS_OFS, 32'h0000_0008, "sleep not refused");
    chk(host_sleep, 1'b0, "slept first");
    wctl(GOOD | 32'h0000_0400);
    wctl(GOOD | 32'h0000_0c00);
    @(posedge clk);
    chk({xcvr_powerdown, host_sleep}, 2'b11, "no sleep");
    wctl(GOOD | 32'h0000_0800);
    @(posedge clk);
    chk(xcvr_powerdown, 1'b1, "radio woke first");
    wctl(GOOD | 32'h0000_0400);
    wctl(GOOD);
    $display("t_power done");
  endtask
  task automatic summarize;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    avs_address = 3'h0;
    avs_writedata = 32'h0000_0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    int_req = 1'b0;
    reply = 8'h00;
    wake_seen = 1'b0;
    low_cnt = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_refuse;
    t_xfer(32'h0000_00bd, 2);
    t_xfer(32'h0000_00b9, 4);
    t_xfer(32'h0000_00be, 8);
    t_xfer(32'h0000_00ba, 16);
    t_int;
    t_power;
    summarize;
  end
  // Whole run is under two thousand cycles; this leaves a wide margin
  initial begin
    #2_000_000;
    err_count++;
    summarize;
  end
endmodule // test_rf_link_spi_master_setup
`default_nettype wire
